/* File: gpp_pkg.sv */
// package for the general purpose pin block: offsets, field positions, timing
// assumes a byte-wide register port and a 250 MHz clock
package gpp_pkg;
    // register offsets
    localparam logic [7:0] GPP_OFS_PIN1 = 8'h41;
    localparam logic [7:0] GPP_OFS_PIN2 = 8'h42;
    localparam logic [7:0] GPP_OFS_PIN3 = 8'h43;
    // field positions
    localparam int GPP_B_SLEEP = 7;
    localparam int GPP_B_SRC = 6;
    localparam int GPP_B_OD = 5;
    localparam int GPP_B_FILT = 4;
    localparam int GPP_B_PD = 3;
    localparam int GPP_B_DIR = 2;
    localparam int GPP_B_LVL = 1;
    localparam int GPP_B_SET = 0;
    // writable bits per register
    localparam logic [7:0] GPP_WMASK_12 = 8'h95;
    localparam logic [7:0] GPP_WMASK_3 = 8'hFD;
    // value while no otp load has happened
    localparam logic [7:0] GPP_RST_VAL = 8'h00;
    // filter times
    localparam int GPP_CLK_MHZ = 250;
    localparam int GPP_FILT_SHORT_US = 94;
    localparam int GPP_FILT_LONG_US = 156;
    localparam int GPP_FILT_SHORT_CYC = GPP_FILT_SHORT_US * GPP_CLK_MHZ;
    localparam int GPP_FILT_LONG_CYC = GPP_FILT_LONG_US * GPP_CLK_MHZ;
    localparam int GPP_CNT_W = 16;
endpackage : gpp_pkg

/* File: gpp_top.sv */
// general purpose pin logic: three pin control registers, filters, pad drive
// assumes otp defaults arrive on otp_* inputs; pad inputs are asynchronous
//
// Contract
// - sleep bit with output mode in sleep state forces pin low
// - input filter lasts 94 us when select is 0, 156 us when 1
// - direction bit 0 makes pad input, 1 makes it output
// - output-configured pin is flagged as a power-up sequence resource, except the third pin in open drain
// - pad level bit is read-only and follows pad voltage live
// - output mode drives the output value bit onto the pin
// - bits 6..5 and 3 of first two registers read zero
// - power-on reset reloads writable fields from otp defaults
// - third pin source select picks value bit or led channel a
// - third pin output type: push-pull sequenced at 0, open drain at 1
// - third pin pulldown select enables pad pulldown at 1
`timescale 1ns/1ps
module gpp_top (
    // clock and reset
    input wire logic clk,
    input wire logic srst,
    // otp defaults
    input wire logic [7:0] otp_pin1,
    input wire logic [7:0] otp_pin2,
    input wire logic [7:0] otp_pin3,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    // device state and led source
    input wire logic sleep_state,
    input wire logic led_channel_a,
    // pads
    input wire logic [2:0] pad_in,
    output logic [2:0] pad_out,
    output logic [2:0] pad_oe,
    output logic pad3_pulldown,
    // filtered inputs and sequencer resources
    output logic [2:0] pin_filtered,
    output logic [2:0] seq_resource
);
    logic [7:0] ctl_ff [3];
    logic [2:0] sync1_ff, sync2_ff, filt_ff;
    logic [15:0] cnt_ff [3];
    logic [7:0] nxt_rdata;
    logic [2:0] nxt_out, nxt_oe;

    // register index from address
    function automatic int gpp_idx(input logic [7:0] a);
        if (a == gpp_pkg::GPP_OFS_PIN1) return 0;
        if (a == gpp_pkg::GPP_OFS_PIN2) return 1;
        if (a == gpp_pkg::GPP_OFS_PIN3) return 2;
        return 3;
    endfunction : gpp_idx

    ////////////////////////////////////////////////////////////////////////////
    // control registers
    always_ff @(posedge clk) begin
        if (srst) begin
            ctl_ff[0] <= otp_pin1 & gpp_pkg::GPP_WMASK_12;
            ctl_ff[1] <= otp_pin2 & gpp_pkg::GPP_WMASK_12;
            ctl_ff[2] <= otp_pin3 & gpp_pkg::GPP_WMASK_3;
        end else if (reg_wr) begin
            unique case (gpp_idx(reg_addr))
                0: ctl_ff[0] <= reg_wdata & gpp_pkg::GPP_WMASK_12;
                1: ctl_ff[1] <= reg_wdata & gpp_pkg::GPP_WMASK_12;
                2: ctl_ff[2] <= reg_wdata & gpp_pkg::GPP_WMASK_3;
                default: ;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // pad synchronisers and filters
    always_ff @(posedge clk) begin
        if (srst) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
        end else begin
            sync1_ff <= pad_in;
            sync2_ff <= sync1_ff;
        end
    end

    genvar g;
    generate
        for (g = 0; g < 3; g++) begin : g_filt
            // filtered level changes only after input held stable for the time
            always_ff @(posedge clk) begin
                if (srst) begin
                    cnt_ff[g] <= 16'h0000;
                    filt_ff[g] <= 1'b0;
                end else if (sync2_ff[g] == filt_ff[g]) begin
                    cnt_ff[g] <= 16'h0000;
                end else if (int'(cnt_ff[g]) + 1 >= (ctl_ff[g][gpp_pkg::GPP_B_FILT] ?
                             gpp_pkg::GPP_FILT_LONG_CYC : gpp_pkg::GPP_FILT_SHORT_CYC)) begin
                    cnt_ff[g] <= 16'h0000;
                    filt_ff[g] <= sync2_ff[g];
                end else begin
                    cnt_ff[g] <= cnt_ff[g] + 16'h0001;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // pad drive
    always_comb begin
        nxt_out = 3'h0;
        nxt_oe = 3'h0;
        for (int i = 0; i < 3; i++) begin
            logic v;
            v = ctl_ff[i][gpp_pkg::GPP_B_SET];
            if (i == 2 && ctl_ff[2][gpp_pkg::GPP_B_SRC]) begin
                v = led_channel_a;
            end
            if (sleep_state && ctl_ff[i][gpp_pkg::GPP_B_SLEEP]) begin
                v = 1'b0;
            end
            if (ctl_ff[i][gpp_pkg::GPP_B_DIR]) begin
                nxt_out[i] = v;
                nxt_oe[i] = 1'b1;
                if (i == 2 && ctl_ff[2][gpp_pkg::GPP_B_OD]) begin
                    nxt_out[i] = 1'b0;
                    nxt_oe[i] = ~v;
                end
            end // input: undriven
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pad_out <= 3'h0;
            pad_oe <= 3'h0;
            pad3_pulldown <= 1'b0;
            seq_resource <= 3'h0;
            pin_filtered <= 3'h0;
        end else begin
            pad_out <= nxt_out;
            pad_oe <= nxt_oe;
            pad3_pulldown <= ctl_ff[2][gpp_pkg::GPP_B_PD];
            pin_filtered <= filt_ff;
            for (int i = 0; i < 3; i++) begin
                seq_resource[i] <= ctl_ff[i][gpp_pkg::GPP_B_DIR]
                    && !(i == 2 && ctl_ff[2][gpp_pkg::GPP_B_OD]);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // readback with live pad level
    always_comb begin
        nxt_rdata = 8'h00;
        unique case (gpp_idx(reg_addr))
            0, 1, 2: begin
                nxt_rdata = ctl_ff[gpp_idx(reg_addr)];
                nxt_rdata[gpp_pkg::GPP_B_LVL] = sync2_ff[gpp_idx(reg_addr)];
            end
            default: nxt_rdata = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            reg_rdata <= 8'h00;
        end else begin
            reg_rdata <= nxt_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // checks
    // register map
    rsvd_zero_a: assert property (@(posedge clk) disable iff (srst)
        (reg_rdata & 8'h68) == 8'h00 || $past(reg_addr) == gpp_pkg::GPP_OFS_PIN3)
        else $error("reserved bits read nonzero");
    // direction and drive
    in_undriven_a: assert property (@(posedge clk) disable iff (srst)
        !ctl_ff[0][2] |=> !pad_oe[0]) else $error("input pad driven");
    in3_undriven_a: assert property (@(posedge clk) disable iff (srst)
        !ctl_ff[2][2] |=> !pad_oe[2]) else $error("third input pad driven");
    sleep_in_a: assert property (@(posedge clk) disable iff (srst)
        !ctl_ff[0][2] && ctl_ff[0][7] && sleep_state |=> !pad_oe[0])
        else $error("sleep force drove an input");
    sleep_low_a: assert property (@(posedge clk) disable iff (srst)
        ctl_ff[0][2] && ctl_ff[0][7] && sleep_state |=> !pad_out[0] && pad_oe[0])
        else $error("sleep force not low");
    sleep_keep_a: assert property (@(posedge clk) disable iff (srst)
        ctl_ff[2][2] && ctl_ff[2][6] && !ctl_ff[2][5] && !ctl_ff[2][7] |=> pad_out[2] == $past(led_channel_a))
        else $error("sleep state changed an unforced pin");
    set_drive_a: assert property (@(posedge clk) disable iff (srst)
        ctl_ff[0][2] && !sleep_state |=> pad_out[0] == $past(ctl_ff[0][0]))
        else $error("output value not driven");
    // third pin options and first pin sequencer flag
    led_src_a: assert property (@(posedge clk) disable iff (srst)
        ctl_ff[2][2] && ctl_ff[2][6] && !ctl_ff[2][5] && !sleep_state |=> pad_out[2] == $past(led_channel_a))
        else $error("led source not driven");
    od_nohigh_a: assert property (@(posedge clk) disable iff (srst)
        ctl_ff[2][5] |=> !pad_out[2]) else $error("open drain drove high");
    od_seq_a: assert property (@(posedge clk) disable iff (srst)
        ctl_ff[2][5] |=> !seq_resource[2]) else $error("open drain pin flagged for sequence");
    pd_follow_a: assert property (@(posedge clk) disable iff (srst)
        1'b1 |=> pad3_pulldown == $past(ctl_ff[2][3])) else $error("pulldown mismatch");
    seq_res_a: assert property (@(posedge clk) disable iff (srst)
        ctl_ff[0][2] |=> seq_resource[0]) else $error("sequencer flag missing");
    // filter
    filt_hold_a: assert property (@(posedge clk) disable iff (srst)
        sync2_ff[0] != filt_ff[0] && cnt_ff[0] == 16'h0000 |=> filt_ff[0] == $past(filt_ff[0]))
        else $error("filter changed early");
    // reset behaviour
    rst_quiet_a: assert property (@(posedge clk)
        srst |=> pad_oe == 3'h0 && seq_resource == 3'h0)
        else $error("pads driven during reset");
    rst_load_a: assert property (@(posedge clk)
        srst |=> ctl_ff[2] == ($past(otp_pin3) & gpp_pkg::GPP_WMASK_3))
        else $error("otp default not loaded");
    // main scenarios
    write_cov_c: cover property (@(posedge clk) reg_wr && reg_addr == gpp_pkg::GPP_OFS_PIN3);
    sleep_cov_c: cover property (@(posedge clk) sleep_state && pad_oe[0]);
    filt_cov_c: cover property (@(posedge clk) filt_ff[0] != $past(filt_ff[0]));
    led_cov_c: cover property (@(posedge clk) ctl_ff[2][6] && pad_oe[2] && !led_channel_a);
endmodule : gpp_top

/* File: gpp_pad_model.sv */
// board side of the three pins: external drivers, block drive, pulls
// assumes board pull-ups on every pin and pad_oe high while the block drives
`timescale 1ns/1ps
module gpp_pad_model (
    // block side
    input wire logic [2:0] pad_out,
    input wire logic [2:0] pad_oe,
    input wire logic pad3_pulldown,
    // board side
    input wire logic [2:0] ext_val,
    input wire logic [2:0] ext_en,
    output logic [2:0] pad_lvl
);
    // level: block drive, then board drive, then pulldown, then pull-up
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pad_lvl[i] = pad_oe[i] ? pad_out[i] : ext_en[i] ? ext_val[i] : !(i == 2 && pad3_pulldown);
        end
    end
endmodule : gpp_pad_model

/* File: tb_gpp_top.sv */
// self-checking bench for the general purpose pin block
// assumes gpp_top from the design files and the pad model beside it
`timescale 1ns/1ps
module tb_gpp_top;
    logic clk = 0, srst = 1, reg_wr = 0, sleep_state = 0, led_channel_a = 1, pad3_pulldown;
    logic [7:0] otp_pin1 = 8'h85, otp_pin2 = 8'h10, otp_pin3 = 8'h2d, reg_addr = 8'h00, reg_wdata = 8'h00;
    logic [7:0] reg_rdata, v;
    logic [2:0] ext_val = 3'h0, ext_en = 3'h2, pad_lvl, pad_out, pad_oe, pin_filtered, seq_resource;
    int num_errors = 0, n_checks = 0, p, n;
    typedef struct { logic [7:0] a, d, rd; logic oe, out, sq; } gpp_row_s;
    gpp_row_s rows[10] = '{'{8'h41, 8'h04, 8'h04, 1, 0, 1}, '{8'h41, 8'h05, 8'h05, 1, 1, 1},
        '{8'h41, 8'hff, 8'h95, 1, 1, 1}, '{8'h41, 8'h00, 8'h00, 0, 0, 0}, '{8'h42, 8'h6e, 8'h04, 1, 0, 1},
        '{8'h43, 8'h25, 8'h25, 0, 0, 0}, '{8'h43, 8'h24, 8'h24, 1, 0, 0}, '{8'h43, 8'h05, 8'h05, 1, 1, 1},
        '{8'h43, 8'h44, 8'h44, 1, 1, 1}, '{8'h44, 8'hff, 8'h00, 0, 0, 0}};
    gpp_top dut_u (.clk(clk), .srst(srst), .otp_pin1(otp_pin1), .otp_pin2(otp_pin2), .otp_pin3(otp_pin3),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .sleep_state(sleep_state), .led_channel_a(led_channel_a), .pad_in(pad_lvl), .pad_out(pad_out),
        .pad_oe(pad_oe), .pad3_pulldown(pad3_pulldown), .pin_filtered(pin_filtered), .seq_resource(seq_resource));
    gpp_pad_model pad_u (.pad_out(pad_out), .pad_oe(pad_oe), .pad3_pulldown(pad3_pulldown),
        .ext_val(ext_val), .ext_en(ext_en), .pad_lvl(pad_lvl));
    // clock, 4 ns period
    initial begin
        forever #2 clk = ~clk;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk_reg(string nm, logic [7:0] e, logic [7:0] g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask : chk_reg
    task automatic chk_pin(string nm, logic e, logic g);
        n_checks++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
        end
    endtask : chk_pin
    // one write, strobe held for one edge
    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(negedge clk);
        reg_wr = 1;
        reg_addr = a;
        reg_wdata = d;
        @(negedge clk);
        reg_wr = 0;
    endtask : wr
    // registered read, data one cycle after the address
    task automatic rd(logic [7:0] a, output logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        @(negedge clk);
        d = reg_rdata;
    endtask : rd
    task automatic results();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : results
    // watchdog, well past both filter runs
    initial begin
        #320000;
        num_errors++;
        results();
    end
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(negedge clk);
        srst = 0;
        rd(8'h41, v);
        chk_reg("rst1", 8'h85, v & 8'hfd);
        chk_pin("rst_out", 1, pad_out[0] & pad_oe[0] & seq_resource[0]);
        rd(8'h42, v);
        chk_reg("rst2", 8'h10, v & 8'hfd);
        rd(8'h43, v);
        chk_reg("rst3", 8'h2d, v & 8'hfd);
        foreach (rows[k]) begin
            wr(rows[k].a, rows[k].d);
            rd(rows[k].a, v);
            chk_reg("reg", rows[k].rd, v & 8'hfd);
            p = int'(rows[k].a) - 'h41;
            if (p < 3) begin
                chk_pin("oe", rows[k].oe, pad_oe[p]);
                chk_pin("seq", rows[k].sq, seq_resource[p]);
                if (rows[k].oe) chk_pin("out", rows[k].out, pad_out[p]);
            end
        end
        // led source follows the led channel
        led_channel_a = 0;
        repeat (2) @(negedge clk);
        chk_pin("led", 0, pad_out[2]);
        led_channel_a = 1;
        // sleep force low, then ignored in input mode
        wr(8'h41, 8'h85);
        sleep_state = 1;
        repeat (3) @(negedge clk);
        chk_pin("sleep", 0, pad_out[0] | !pad_oe[0]);
        chk_pin("no_force", 1, pad_out[2] & pad_oe[2]);
        wr(8'h41, 8'h81);
        repeat (2) @(negedge clk);
        chk_pin("in_oe", 0, pad_oe[0]);
        sleep_state = 0;
        // live pad level on an input pin
        wr(8'h42, 8'h00);
        for (int i = 1; i >= 0; i--) begin
            ext_val[1] = i[0];
            repeat (4) @(negedge clk);
            rd(8'h42, v);
            chk_pin("lvl", i[0], v[1]);
        end
        // pulldown on the third pin
        ext_en[2] = 0;
        wr(8'h43, 8'h08);
        repeat (3) @(negedge clk);
        rd(8'h43, v);
        chk_pin("pd", 1, pad3_pulldown & !v[1]);
        // filter length for both selects
        for (int s = 0; s < 2; s++) begin
            n = s ? gpp_pkg::GPP_FILT_LONG_CYC : gpp_pkg::GPP_FILT_SHORT_CYC;
            wr(8'h42, s ? 8'h10 : 8'h00);
            ext_val[1] = !s;
            repeat (n - 100) @(negedge clk);
            chk_pin("filt_hold", s, pin_filtered[1]);
            repeat (200) @(negedge clk);
            chk_pin("filt_new", !s, pin_filtered[1]);
        end
        // mid-run reset reloads new otp defaults, reserved bits stay clear
        otp_pin1 = 8'h7a;
        otp_pin3 = 8'h05;
        srst = 1;
        repeat (2) @(negedge clk);
        chk_reg("rst_oe", 8'h00, {5'h00, pad_oe});
        chk_reg("rst_seq", 8'h00, {5'h00, seq_resource});
        srst = 0;
        rd(8'h41, v);
        chk_reg("rst1b", 8'h10, v & 8'hfd);
        rd(8'h43, v);
        chk_reg("rst3b", 8'h05, v & 8'hfd);
        chk_pin("rst_drv", 1, pad_oe[2] & pad_out[2] & seq_resource[2]);
        results();
    end
endmodule : tb_gpp_top
